//--- pwt_consts.svh
// Register offsets, field positions, reset values and counts for the timer
// Included by the prescaler and timer modules
`ifndef PWT_CONSTS_SVH
`define PWT_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PWT_OFS_CTRL 8'h00
`define PWT_OFS_COUNT 8'h04
`define PWT_OFS_COMPARE 8'h08
`define PWT_OFS_FLAGS 8'h0c
`define PWT_OFS_PIN 8'h10

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PWT_CTRL_FORCE 7
`define PWT_CTRL_WGM0 6
`define PWT_CTRL_COM_HI 5
`define PWT_CTRL_COM_LO 4
`define PWT_CTRL_WGM1 3
`define PWT_CTRL_CS_HI 2
`define PWT_CTRL_CS_LO 0

// ----------------------------------------------------------------
// Flag register fields (write one to clear)
// ----------------------------------------------------------------
`define PWT_FLAG_CMP 1
`define PWT_FLAG_OVF 0

// ----------------------------------------------------------------
// Reset values and counter limits
// ----------------------------------------------------------------
`define PWT_RST_BYTE 8'h00
`define PWT_MAX 8'hff
`define PWT_BOTTOM 8'h00
`define PWT_PRESCALE_W 10

`endif

//--- pwt_pkg.sv
// Types shared by the timer modules
// Assumes pwt_consts.svh is on the include path
package pwt_pkg;
  typedef enum logic [1:0] {
    PWT_NORMAL,
    PWT_PHASE,
    PWT_CTC,
    PWT_FAST
  } pwt_mode_t;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic [1:0] com;
    pwt_mode_t mode;
  } pwt_cfg_t;

  typedef struct packed {
    logic cmp;
    logic ovf;
  } pwt_flags_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pwt_axi_s2m_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } pwt_axi_m2s_t;
endpackage

//--- pwt_prescaler.sv
// Prescaler producing the timer tick enable from aclk
// Assumes a clock-select code 0..7; code 0 stops the timer
`timescale 1ns/100ps
`include "pwt_consts.svh"
module pwt_prescaler #(
  parameter int unsigned W = `PWT_PRESCALE_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] clk_sel,
  output logic tick
);
  import pwt_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } pwt_pre_state_t;

  pwt_pre_state_t s_q, s_d;
  logic [W-1:0] mask;

  // ----------------------------------------------------------------
  // Divide by 1, 8, 32, 64, 128, 256, 1024
  // ----------------------------------------------------------------
  always_comb begin
    unique case (clk_sel)
      3'h1: mask = W'(0);
      3'h2: mask = W'(7);
      3'h3: mask = W'(31);
      3'h4: mask = W'(63);
      3'h5: mask = W'(127);
      3'h6: mask = W'(255);
      3'h7: mask = W'(1023);
      default: mask = W'(0);
    endcase
    s_d = s_q;
    s_d.cnt = s_q.cnt + W'(1);
  end

  assign tick = (clk_sel != 3'h0) && ((s_q.cnt & mask) == W'(0));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_tick_stops: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_sel == 3'h0 |-> !tick)
    else $error("tick while stopped");
  a_tick_div8: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && clk_sel == 3'h2 && $stable(clk_sel)) ##1 (clk_sel == 3'h2)
      [*7] |-> !$past(tick))
    else $error("div8 tick too early");
endmodule

//--- pwt_axi_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
// Assumes the core answers reads combinationally from rd_addr
`timescale 1ns/100ps
module pwt_axi_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pwt_pkg::pwt_axi_m2s_t m2s,
  output pwt_pkg::pwt_axi_s2m_t s2m,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok,
  input wire logic wr_ok
);
  import pwt_pkg::*;

  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pwt_axi_state_t;

  pwt_axi_state_t s_q, s_d;
  logic aw_go, w_go, ar_go;

  assign aw_go = m2s.awvalid && !s_q.aw_have && !s_q.bvalid;
  assign w_go = m2s.wvalid && !s_q.w_have && !s_q.bvalid;
  assign ar_go = m2s.arvalid && !s_q.rvalid;
  assign rd_addr = m2s.araddr;
  assign wr_en = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign wr_addr = s_q.awaddr;
  assign wr_data = s_q.wdata;
  assign wr_strb = s_q.wstrb;

  always_comb begin
    s_d = s_q;
    if (aw_go) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = m2s.awaddr;
    end
    if (w_go) begin
      s_d.w_have = 1'b1;
      s_d.wdata = m2s.wdata;
      s_d.wstrb = m2s.wstrb;
    end
    if (wr_en) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_ok ? 2'h0 : 2'h2;
    end
    if (s_q.bvalid && m2s.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (ar_go) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_ok ? rd_data : 32'h0000_0000;
      s_d.rresp = rd_ok ? 2'h0 : 2'h2;
    end else if (s_q.rvalid && m2s.rready) begin
      s_d.rvalid = 1'b0;
    end
  end

  always_comb begin
    s2m.awready = aw_go;
    s2m.wready = w_go;
    s2m.bvalid = s_q.bvalid;
    s2m.bresp = s_q.bresp;
    s2m.arready = ar_go;
    s2m.rvalid = s_q.rvalid;
    s2m.rdata = s_q.rdata;
    s2m.rresp = s_q.rresp;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

//--- pwt_timer.sv
// 8-bit waveform timer: clear-on-compare, fast PWM, phase-correct PWM
// Assumes AXI4-Lite master on aclk; pin direction bit from the port block
//
// Operation
// - Clear-on-compare counts up to compare value, then clears to zero.
// - Clear-on-compare compare unbuffered; missed match waits for wrap past 0xff.
// - Clear-on-compare sets compare flag whenever count reaches top.
// - Clear-on-compare with output mode 1 toggles output each match.
// - Waveform output reaches pin only while direction bit selects output.
// - Clear-on-compare sets overflow flag when count rolls 0xff to 0x00, except on a compare match at 0xff.
// - Mode 3 is fast PWM counting bottom to maximum, then restarting.
// - Fast PWM holds maximum one tick then clears; 256 tick period.
// - Fast PWM sets overflow flag each time count reaches maximum.
// - Fast PWM mode 2 clears on match/sets at bottom; 3 inverse.
// - Fast PWM applies match action on equality, opposite at wrap.
// - Fast PWM compare bottom gives spike; maximum gives constant level.
// - Fast PWM mode 1 toggles on match; compare stays double buffered.
// - Mode 1 is phase-correct PWM counting up then down repeatedly.
// - Phase-correct reverses at maximum, held one tick; 510 tick period.
// - Phase-correct sets overflow flag at bottom rather than maximum.
// - Phase-correct mode 2 clears on up match, sets on down match.
// - Phase-correct mode 2 compare bottom gives constant low, maximum constant high.
// - Phase-correct applies up-count match result at maximum for symmetry.
// - Timer tick acts as enable qualifying the single clock.
// - Tick enable from prescaler dividing by 1,8,32,64,128,256,1024.
// - Phase-correct resolution fixed at eight bits, top 0xff.
// - Force strobe acts at once in non-PWM modes; no flag, no clear.
// - Software count write suppresses compare match on next tick.
// - PWM with compare at top and high mode bit: act at top only.
`timescale 1ns/100ps
`include "pwt_consts.svh"
module pwt_timer #(
  parameter int unsigned PRESCALE_W = `PWT_PRESCALE_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pwt_pkg::pwt_axi_m2s_t axi_m2s,
  output pwt_pkg::pwt_axi_s2m_t axi_s2m,
  input wire logic pin_dir_out,
  output logic waveform_output,
  output logic pin_out,
  output logic pin_oe,
  output logic compare_match_flag,
  output logic overflow_flag
);
  import pwt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pwt_cfg_t cfg;
    logic [7:0] count_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buf;
    logic count_down;
    logic block_match;
    logic wave;
    pwt_flags_t flags;
  } pwt_state_t;

  pwt_state_t s_q, s_d;

  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic wr_ok;
  logic tick;

  pwt_axi_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .m2s(axi_m2s),
    .s2m(axi_s2m),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok),
    .wr_ok(wr_ok)
  );

  pwt_prescaler #(
    .W(PRESCALE_W)
  ) u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_sel(s_q.cfg.clk_sel),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wr_lane0;
  logic wr_ctrl, wr_count, wr_compare, wr_flags;
  logic force_compare_strobe;
  logic [7:0] ctrl_rd;

  assign wr_lane0 = wr_en && wr_strb[0];
  assign wr_ctrl = wr_lane0 && wr_addr == `PWT_OFS_CTRL;
  assign wr_count = wr_lane0 && wr_addr == `PWT_OFS_COUNT;
  assign wr_compare = wr_lane0 && wr_addr == `PWT_OFS_COMPARE;
  assign wr_flags = wr_lane0 && wr_addr == `PWT_OFS_FLAGS;
  assign force_compare_strobe = wr_ctrl && wr_data[`PWT_CTRL_FORCE];

  always_comb begin
    ctrl_rd = 8'h00;
    // Force bit always reads zero
    ctrl_rd[`PWT_CTRL_FORCE] = 1'b0;
    ctrl_rd[`PWT_CTRL_WGM0] = s_q.cfg.mode[0];
    ctrl_rd[`PWT_CTRL_WGM1] = s_q.cfg.mode[1];
    ctrl_rd[`PWT_CTRL_COM_HI:`PWT_CTRL_COM_LO] = s_q.cfg.com;
    ctrl_rd[`PWT_CTRL_CS_HI:`PWT_CTRL_CS_LO] = s_q.cfg.clk_sel;
  end

  always_comb begin
    rd_ok = 1'b1;
    unique case (rd_addr)
      `PWT_OFS_CTRL: rd_data = {24'h000000, ctrl_rd};
      `PWT_OFS_COUNT: rd_data = {24'h000000, s_q.count_value};
      `PWT_OFS_COMPARE: rd_data = {24'h000000, s_q.compare_buf};
      `PWT_OFS_FLAGS: rd_data = {30'h0, s_q.flags};
      `PWT_OFS_PIN: rd_data = {30'h0, pin_dir_out, s_q.wave};
      default: begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign wr_ok = (wr_addr == `PWT_OFS_CTRL) || (wr_addr == `PWT_OFS_COUNT)
    || (wr_addr == `PWT_OFS_COMPARE) || (wr_addr == `PWT_OFS_FLAGS)
    || (wr_addr == `PWT_OFS_PIN);

  // ----------------------------------------------------------------
  // Counter and waveform
  // ----------------------------------------------------------------
  logic is_pwm, at_max, at_bottom, match, wrap_fast;
  logic [7:0] cv;

  assign is_pwm = s_q.cfg.mode == PWT_FAST || s_q.cfg.mode == PWT_PHASE;
  assign cv = s_q.compare_value;
  assign at_max = s_q.count_value == `PWT_MAX;
  assign at_bottom = s_q.count_value == `PWT_BOTTOM;
  assign match = s_q.count_value == cv && !s_q.block_match;
  assign wrap_fast = s_q.cfg.mode == PWT_FAST && at_max;

  always_comb begin
    s_d = s_q;
    // Write one to clear; any set later in this cycle wins
    if (wr_flags) begin
      if (wr_data[`PWT_FLAG_CMP]) begin
        s_d.flags.cmp = 1'b0;
      end
      if (wr_data[`PWT_FLAG_OVF]) begin
        s_d.flags.ovf = 1'b0;
      end
    end
    if (tick) begin
      s_d.block_match = 1'b0;
      unique case (s_q.cfg.mode)
        PWT_NORMAL: begin
          s_d.count_value = s_q.count_value + 8'h01;
          if (at_max) s_d.flags.ovf = 1'b1;
          if (match) s_d.flags.cmp = 1'b1;
        end
        PWT_CTC: begin
          if (match) begin
            s_d.count_value = `PWT_BOTTOM;
            s_d.flags.cmp = 1'b1;
          end else begin
            // Unbuffered compare: a missed match wraps through 0xff
            s_d.count_value = s_q.count_value + 8'h01;
          end
          if (at_max && !match) s_d.flags.ovf = 1'b1;
        end
        PWT_FAST: begin
          // Count up, hold max one tick, then bottom
          s_d.count_value = s_q.count_value + 8'h01;
          if (at_max) begin
            s_d.flags.ovf = 1'b1;
            s_d.compare_value = s_q.compare_buf;
          end
          if (match) s_d.flags.cmp = 1'b1;
        end
        PWT_PHASE: begin
          // Fixed 8-bit top, direction flips at max and bottom
          if (s_q.count_down) begin
            s_d.count_value = s_q.count_value - 8'h01;
            if (s_q.count_value == 8'h01) s_d.count_down = 1'b0;
          end else begin
            s_d.count_value = s_q.count_value + 8'h01;
            if (s_q.count_value == 8'hfe) s_d.count_down = 1'b1;
          end
          if (at_max) begin
            s_d.count_value = 8'hfe;
            s_d.count_down = 1'b1;
            s_d.compare_value = s_q.compare_buf;
          end
          if (at_bottom) begin
            s_d.count_value = 8'h01;
            s_d.count_down = 1'b0;
            s_d.flags.ovf = 1'b1;
          end
          if (match) s_d.flags.cmp = 1'b1;
        end
      endcase

      // Output action
      unique case (s_q.cfg.mode)
        PWT_NORMAL, PWT_CTC: begin
          if (match) begin
            unique case (s_q.cfg.com)
              2'h1: s_d.wave = !s_q.wave;
              2'h2: s_d.wave = 1'b0;
              2'h3: s_d.wave = 1'b1;
              default: s_d.wave = s_q.wave;
            endcase
          end
        end
        PWT_FAST: begin
          if (s_q.cfg.com == 2'h1) begin
            if (match) s_d.wave = !s_q.wave;
          end else if (s_q.cfg.com[1]) begin
            // Match at top ignored, level set at wrap instead
            if (match && cv != `PWT_MAX) begin
              s_d.wave = s_q.cfg.com[0];
            end
            if (wrap_fast) begin
              // Spike at compare bottom, constant at max
              s_d.wave = !s_q.cfg.com[0];
            end
          end
        end
        PWT_PHASE: begin
          if (s_q.cfg.com[1]) begin
            if (at_max) begin
              // At top: compare max holds down-match level, else up-match level
              s_d.wave = (cv == `PWT_MAX) ? !s_q.cfg.com[0]
                : s_q.cfg.com[0];
            end else if (match) begin
              s_d.wave = s_q.count_down ? !s_q.cfg.com[0]
                : s_q.cfg.com[0];
            end
            if (cv == `PWT_BOTTOM && at_bottom) begin
              s_d.wave = s_q.cfg.com[0];
            end
          end
        end
      endcase
    end

    // Forced compare in non-PWM modes, no flag and no clear
    if (force_compare_strobe && !is_pwm) begin
      unique case (s_q.cfg.com)
        2'h1: s_d.wave = !s_q.wave;
        2'h2: s_d.wave = 1'b0;
        2'h3: s_d.wave = 1'b1;
        default: s_d.wave = s_q.wave;
      endcase
    end

    // Software writes
    if (wr_ctrl) begin
      s_d.cfg.mode = pwt_mode_t'({wr_data[`PWT_CTRL_WGM1],
        wr_data[`PWT_CTRL_WGM0]});
      s_d.cfg.com = wr_data[`PWT_CTRL_COM_HI:`PWT_CTRL_COM_LO];
      s_d.cfg.clk_sel = wr_data[`PWT_CTRL_CS_HI:`PWT_CTRL_CS_LO];
    end
    if (wr_count) begin
      s_d.count_value = wr_data[7:0];
      s_d.block_match = 1'b1;
    end
    if (wr_compare) begin
      s_d.compare_buf = wr_data[7:0];
      if (!is_pwm) s_d.compare_value = wr_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign waveform_output = s_q.wave;
  assign pin_out = s_q.wave;
  assign pin_oe = pin_dir_out && s_q.cfg.com != 2'h0;
  assign compare_match_flag = s_q.flags.cmp;
  assign overflow_flag = s_q.flags.ovf;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence ctc_hit;
    tick && s_q.cfg.mode == PWT_CTC && match && !wr_en;
  endsequence

  a_ctc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    ctc_hit |=> s_q.count_value == 8'h00 && s_q.flags.cmp)
    else $error("ctc match did not clear counter");
  a_ctc_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    ctc_hit and s_q.cfg.com == 2'h1 |=> s_q.wave != $past(s_q.wave))
    else $error("ctc toggle missing");
  a_pin_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    !pin_dir_out |-> !pin_oe)
    else $error("pin driven while input");
  a_ctc_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && s_q.cfg.mode == PWT_CTC && at_max && !match && !wr_en
      |=> s_q.flags.ovf && s_q.count_value == 8'h00)
    else $error("ctc overflow flag missing");
  a_fast_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && wrap_fast && !wr_en |=> s_q.count_value == 8'h00
      && s_q.flags.ovf)
    else $error("fast pwm wrap wrong");
  a_fast_noninv: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && wrap_fast && s_q.cfg.com == 2'h2 && !wr_en
      |=> s_q.wave)
    else $error("fast pwm not set at bottom");
  a_phase_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && s_q.cfg.mode == PWT_PHASE && at_bottom && !wr_en
      |=> s_q.flags.ovf && s_q.count_value == 8'h01)
    else $error("phase overflow not at bottom");
  a_phase_turn: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && s_q.cfg.mode == PWT_PHASE && at_max && !wr_en
      |=> s_q.count_down && s_q.count_value == 8'hfe)
    else $error("phase did not reverse at max");
  a_force_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    force_compare_strobe && !tick && !wr_flags
      |=> $stable(s_q.flags) && $stable(s_q.count_value))
    else $error("force strobe disturbed flags or count");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.flags.cmp && !wr_flags |=> s_q.flags.cmp)
    else $error("compare flag dropped");
endmodule

//--- pwt_pin_load.sv
// Port pin driver and external load seen by the waveform timer
// Assumes pin_out and pin_oe come from the timer on aclk
`timescale 1ns/100ps
module pwt_pin_load (
  input wire logic aclk,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pad
);
  logic flt_q;
  // ----------------------------------------------------------------
  // Undriven pad drifts to the opposite of the last drive value
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    flt_q <= ~pin_out;
  end
  assign pad = pin_oe ? pin_out : flt_q;
endmodule

//--- tb.sv
// Self-checking bench for the waveform timer
// Assumes pwt_pkg, pwt_timer and pwt_pin_load are compiled first
`timescale 1ns/100ps
module tb;
  import pwt_pkg::*;
  typedef struct {
    logic [7:0] c, k;
    int w, h, e;
    logic [1:0] f;
  } pwt_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic pin_dir_out = 1'b1;
  pwt_axi_m2s_t m = '0;
  pwt_axi_s2m_t s;
  logic wf, po, oe, cf, of, pad;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [1:0] br;
  int bad_count = 0;
  int samples_checked = 0;
  int hi, ed;
  // Control byte, compare, window, high cycles, edges, flags
  pwt_row_t rows[15] = '{
    '{8'h19, 8'h03, 64, 32, 16, 2'b10}, '{8'h1a, 8'h00, 64, 32, 8, 2'b10},
    '{8'h1b, 8'h00, 256, 128, 8, 2'b10}, '{8'h1c, 8'h00, 512, 256, 8, 2'b10},
    '{8'h1d, 8'h00, 1024, 512, 8, 2'b10},
    '{8'h1e, 8'h00, 2048, 1024, 8, 2'b10},
    '{8'h1f, 8'h00, 8192, 4096, 8, 2'b10},
    '{8'h69, 8'h40, 256, 65, 2, 2'b11}, '{8'h79, 8'h40, 256, 191, 2, 2'b11},
    '{8'h69, 8'h00, 256, 1, 2, 2'b11}, '{8'h69, 8'hff, 256, 256, 0, 2'b11},
    '{8'h59, 8'h00, 512, 256, 2, 2'b11}, '{8'h61, 8'h40, 510, 128, 2, 2'b11},
    '{8'h71, 8'h40, 510, 382, 2, 2'b11}, '{8'h61, 8'h00, 510, 0, 0, 2'b11}};

  initial forever #2 aclk = ~aclk;

  pwt_timer i_dut (.aclk(aclk), .aresetn(aresetn), .axi_m2s(m),
    .axi_s2m(s), .pin_dir_out(pin_dir_out), .waveform_output(wf),
    .pin_out(po), .pin_oe(oe), .compare_match_flag(cf),
    .overflow_flag(of));
  pwt_pin_load i_load (.aclk(aclk), .pin_out(po), .pin_oe(oe), .pad(pad));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] v, e);
    samples_checked++;
    if (v !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    m.awaddr <= a; m.wdata <= d; m.wstrb <= 4'hf;
    m.awvalid <= 1'b1; m.wvalid <= 1'b1; m.bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s.awready) m.awvalid <= 1'b0;
      if (s.wready) m.wvalid <= 1'b0;
      if (s.bvalid) break;
    end
    br = s.bresp;
    m.bready <= 1'b0;
    if (n == 100) begin bad_count++; final_report(); end
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    m.araddr <= a; m.arvalid <= 1'b1; m.rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s.arready) m.arvalid <= 1'b0;
      if (s.rvalid) break;
    end
    rd = s.rdata; rr = s.rresp;
    m.rready <= 1'b0;
    if (n == 100) begin bad_count++; final_report(); end
  endtask
  task automatic meas(input int w);
    logic p;
    hi = 0; ed = 0;
    @(posedge aclk);
    p = pad;
    repeat (w) begin
      @(posedge aclk);
      if (pad === 1'b1) hi++;
      if (pad !== p) ed++;
      p = pad;
    end
  endtask
  task automatic stop_clear();
    axw(8'h00, 0);
    axw(8'h0c, 3);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i, n;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      stop_clear();
      axw(8'h04, 8'hff);
      axw(8'h08, rows[i].k);
      axw(8'h00, rows[i].c);
      repeat (rows[i].w + 1100) @(posedge aclk);
      axw(8'h0c, 3);
      meas(rows[i].w);
      chk("high cycles", hi, rows[i].h);
      chk("edges", ed, rows[i].e);
      chk("flags", {cf, of}, rows[i].f);
      stop_clear();
      axr(8'h0c);
      chk("flags cleared", rd, 0);
      $display("row %0d done", i);
    end
    // Compare rewritten below the count
    stop_clear();
    axw(8'h04, 8'h10); axw(8'h08, 8'h05); axw(8'h00, 8'h09);
    for (n = 0; n < 600 && cf !== 1'b1; n++) @(posedge aclk);
    chk("late match", cf, 1);
    chk("overflow before match", of, 1);
    $display("late match done");
    // Count write blocks the next match
    stop_clear();
    axw(8'h08, 8'h20); axw(8'h04, 8'h20); axw(8'h00, 8'h09);
    repeat (40) @(posedge aclk);
    chk("blocked match", cf, 0);
    $display("blocked match done");
    // Forced compare with set, then clear
    for (i = 0; i < 2; i++) begin
      stop_clear();
      axw(8'h04, 8'h07);
      axw(8'h00, i ? 8'h28 : 8'h38);
      axw(8'h00, i ? 8'ha8 : 8'hb8);
      chk("write resp", br, 2'b00);
      repeat (3) @(posedge aclk);
      chk("forced level", wf, i ? 0 : 1);
      chk("forced flag", {cf, of}, 0);
      axr(8'h04);
      chk("count kept", rd, 8'h07);
      axr(8'h00);
      chk("strobe reads zero", rd, i ? 8'h28 : 8'h38);
    end
    $display("force done");
    pin_dir_out <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("pin released", oe, 0);
    chk("pad released", pad, !po);
    // Second reset, then reset values and an unmapped read
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      axr(8'(4 * i));
      chk("reset value", rd, 0);
      chk("reset resp", rr, 2'b00);
    end
    axr(8'h14);
    chk("unmapped resp", rr, 2'b10);
    axw(8'h14, 0);
    chk("unmapped bresp", br, 2'b10);
    chk("reset outputs", {wf, cf, of}, 0);
    $display("reset done");
    final_report();
  end
endmodule
